// ==== bench/pfsa_checker.sv ====
// Assertion checker for the program flash self-access block
`timescale 1ns/10ps
module pfsa_checker (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ctrl_we,
  input wire pfsa_pkg::pfsa_ctrl_t ctrl_wdata,
  input wire logic data_low_we,
  input wire logic [1:0] write_protect_field,
  input wire logic [13:0] array_rdata,
  input wire logic [7:0] flash_addr_low_reg,
  input wire logic [7:0] flash_addr_high_reg,
  input wire logic [7:0] flash_data_low_reg,
  input wire logic [7:0] flash_data_high_reg,
  input wire pfsa_pkg::pfsa_ctrl_t flash_control_reg,
  input wire logic write_error,
  input wire logic cpu_ignore,
  input wire pfsa_pkg::pfsa_arr_req_t array_req
);
  logic [13:0] rdata_q; // Word offered in the read slot
  wire idle = !flash_control_reg.rd && !flash_control_reg.wr; // No operation running
  wire go = ctrl_we && idle && ctrl_wdata.program_memory_select
    && !ctrl_wdata.config_space_select; // Accepted program-space request
  wire [9:0] row = {flash_addr_high_reg[6:0], flash_addr_low_reg[7:5]}; // Addressed row
  // Keep the array word so the load can be compared a cycle later
  always_ff @(posedge clk_sys) rdata_q <= array_rdata;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_read_stall: assert property (go && ctrl_wdata.rd
    |-> ##2 (cpu_ignore && array_req.rd))
    else $error("read strobe did not stall the second slot");
  a_ignore_once: assert property (cpu_ignore |=> !cpu_ignore)
    else $error("stall lasted more than one slot");
  a_read_load: assert property (array_req.rd |=> flash_data_low_reg == rdata_q[7:0]
    && flash_data_high_reg == {2'h0, rdata_q[13:8]})
    else $error("read word not placed in data pair");
  a_high_zero: assert property (flash_data_high_reg[7:6] == 2'h0)
    else $error("unused data high bits set");
  a_strobe_clear: assert property (array_req.rd |=> !flash_control_reg.rd)
    else $error("read strobe not cleared");
  a_pair_holds: assert property ($changed(flash_data_low_reg)
    |-> $past(array_req.rd) || $past(data_low_we))
    else $error("data pair changed without read or write");
  a_protect_error: assert property (go && ctrl_wdata.wr && !ctrl_wdata.rd
    && write_protect_field == 2'h0 |-> ##[1:3] write_error)
    else $error("protected write raised no error");
  a_protect_quiet: assert property (go && ctrl_wdata.wr && !ctrl_wdata.rd
    && write_protect_field == 2'h0 |=> (!array_req.erase && !array_req.prog) [*3])
    else $error("protected write reached the array");
  a_erase_row: assert property (go && ctrl_wdata.wr && ctrl_wdata.free
    && !ctrl_wdata.rd && write_protect_field == 2'h3
    |=> array_req.erase && array_req.addr == {row, 5'h00})
    else $error("erase missing or not row aligned");
  a_prog_row: assert property (array_req.prog |-> array_req.addr[14:5] == row)
    else $error("programming left the addressed row");
endmodule
bind pfsa_top pfsa_checker chk (.clk_sys, .reset_n, .ctrl_we, .ctrl_wdata, .data_low_we,
  .write_protect_field, .array_rdata, .flash_addr_low_reg, .flash_addr_high_reg,
  .flash_data_low_reg, .flash_data_high_reg, .flash_control_reg, .write_error,
  .cpu_ignore, .array_req);

// ==== bench/pfsa_flash_model.sv ====
// Behavioural flash array facing the sequencer's array port
`timescale 1ns/10ps
module pfsa_flash_model (
  input wire logic clk_sys,
  input wire pfsa_pkg::pfsa_arr_req_t array_req,
  input wire logic [13:0] array_wdata,
  output logic [13:0] array_rdata
);
  logic [13:0] mem [0:32767]; // Cells, erased reads all ones
  logic [13:0] junk_q = 14'h2AAA; // Toggles so a stale word is never mistaken
  initial for (int i = 0; i < 32768; i++) mem[i] = 14'h3FFF;
  // Word only while a read is asked for
  assign array_rdata = array_req.rd ? mem[array_req.addr] : junk_q;
  // Whole-row erase and single-word programming
  always @(posedge clk_sys) begin
    junk_q <= ~junk_q;
    if (array_req.erase)
      for (int i = 0; i < 32; i++) mem[{array_req.addr[14:5], i[4:0]}] = 14'h3FFF;
    if (array_req.prog) mem[array_req.addr] = array_wdata;
  end
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench for the program flash self-access block
`timescale 1ns/10ps
module tb_top;
  logic clk_sys = 1'h0;
  logic reset_n = 1'h0;
  logic addr_low_we = 1'h0, addr_high_we = 1'h0, data_low_we = 1'h0, data_high_we = 1'h0;
  logic ctrl_we = 1'h0;
  logic [7:0] wdata = 8'h00;
  pfsa_pkg::pfsa_ctrl_t ctrl_wdata = '0;
  logic [1:0] write_protect_field = 2'h3;
  logic code_protect_bit = 1'h0;
  logic [13:0] array_rdata, array_wdata;
  logic [7:0] flash_addr_low_reg, flash_addr_high_reg, flash_data_low_reg, flash_data_high_reg;
  pfsa_pkg::pfsa_ctrl_t flash_control_reg;
  pfsa_pkg::pfsa_arr_req_t array_req;
  logic write_error, cpu_ignore;
  logic [13:0] expect_q [0:31]; // What the test row should hold
  logic [13:0] saved_q [0:31]; // Row kept by software before an erase
  integer mismatches = 0, checked = 0, seed = 37072;
  always #2 clk_sys = ~clk_sys;
  pfsa_top uut (.clk_sys, .reset_n, .addr_low_we, .addr_high_we, .data_low_we, .data_high_we,
    .ctrl_we, .wdata, .ctrl_wdata, .write_protect_field, .code_protect_bit, .array_rdata,
    .flash_addr_low_reg, .flash_addr_high_reg, .flash_data_low_reg, .flash_data_high_reg,
    .flash_control_reg, .write_error, .cpu_ignore, .array_req, .array_wdata);
  pfsa_flash_model array_model (.clk_sys, .array_req, .array_wdata, .array_rdata);
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One-cycle strobe on the selected write port, then a gap edge
  // Select bits: 0 address low, 1 address high, 2 data low, 3 data high
  task automatic poke(input logic [3:0] sel, input logic [7:0] b);
    wdata <= b;
    {data_high_we, data_low_we, addr_high_we, addr_low_we} <= sel;
    @(posedge clk_sys);
    {data_high_we, data_low_we, addr_high_we, addr_low_we} <= 4'h0;
    @(posedge clk_sys);
  endtask
  // Issue a control write and wait, bounded, for the sequencer to go idle
  // Nothing else is issued while the stalled slots pass
  task automatic op(logic [5:0] c);
    ctrl_wdata <= c;
    ctrl_we <= 1'h1;
    @(posedge clk_sys);
    ctrl_we <= 1'h0;
    for (int n = 0; n < 100; n++) begin
      @(posedge clk_sys);
      if (flash_control_reg.rd === 1'h0 && flash_control_reg.wr === 1'h0) return;
    end
    mismatches++;
    wrap_up;
  endtask
  task automatic at(logic [14:0] a);
    poke(4'h1, a[7:0]);
    poke(4'h2, {1'h0, a[14:8]});
  endtask
  task automatic rd_chk(logic [14:0] a, logic [13:0] exp);
    at(a);
    chk("addr low", a[7:0], flash_addr_low_reg);
    chk("addr high", {1'h0, a[14:8]}, flash_addr_high_reg);
    code_protect_bit <= 1'($random(seed));
    op(6'h18);
    chk("data low", exp[7:0], flash_data_low_reg);
    chk("data high", {2'h0, exp[13:8]}, flash_data_high_reg);
  endtask
  // Load one hidden latch of row 0x100 through the data pair
  task automatic ld(logic [4:0] i, logic [13:0] w);
    poke(4'h1, {3'h0, i});
    poke(4'h4, w[7:0]);
    poke(4'h8, {2'h0, w[13:8]});
  endtask
  // Protection map: all, below 0x1000, below 0x200, none
  function automatic logic prot(logic [1:0] f, logic [14:0] a);
    return f == 2'h0 || (f == 2'h1 && a < 15'h1000) || (f == 2'h2 && a < 15'h0200);
  endfunction
  initial begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'h1;
    @(posedge clk_sys);
    at(15'h0100);
    op(6'h16);
    rd_chk(15'h0117, 14'h3FFF);
    // Partial row: ends always loaded, the middle at random
    for (int i = 0; i < 32; i++) begin
      expect_q[i] = 14'h3FFF;
      if (i == 0 || i == 31 || $random(seed) % 2) begin
        expect_q[i] = 14'($random(seed));
        ld(5'(i), expect_q[i]);
      end
    end
    at(15'h0100);
    op(6'h14);
    // Read the row back; software keeps what it read
    for (int i = 0; i < 32; i++) begin
      rd_chk(15'h0100 | 15'(i), expect_q[i]);
      saved_q[i] = {flash_data_high_reg[5:0], flash_data_low_reg};
    end
    repeat (5) @(posedge clk_sys);
    chk("held low", expect_q[31][7:0], flash_data_low_reg);
    poke(4'h4, 8'h5A);
    chk("written low", 8'h5A, flash_data_low_reg);
    // Change two words of a programmed row: erase, reload every latch
    expect_q[5] = 14'($random(seed));
    expect_q[20] = 14'h0000;
    saved_q[5] = expect_q[5];
    saved_q[20] = expect_q[20];
    at(15'h0100);
    op(6'h16);
    for (int i = 0; i < 32; i++) ld(5'(i), saved_q[i]);
    at(15'h0100);
    op(6'h14);
    for (int i = 0; i < 32; i++) rd_chk(15'h0100 | 15'(i), expect_q[i]);
    // Erase attempts under every protection setting
    for (int f = 0; f < 4; f++) begin
      write_protect_field <= f[1:0];
      at(15'h0100);
      op(6'h16);
      repeat (3) @(posedge clk_sys);
      chk("error flag", {7'h00, prot(f[1:0], 15'h0100)}, {7'h00, write_error});
      rd_chk(15'h0100, prot(f[1:0], 15'h0100) ? expect_q[0] : 14'h3FFF);
    end
    wrap_up;
  end
endmodule

// ==== pkg/pfsa_pkg.sv ====
// Types shared by the program flash self-access block
package pfsa_pkg;
  // Control register bits written by software
  typedef struct packed {
    logic config_space_select;
    logic program_memory_select;
    logic rd;
    logic wr;
    logic free;
    logic lwlo;
  } pfsa_ctrl_t;
  // Array port request
  typedef struct packed {
    logic rd;
    logic erase;
    logic prog;
    logic [14:0] addr;
  } pfsa_arr_req_t;
  // Sequencer states
  typedef enum logic [4:0] {
    PFSA_IDLE  = 5'h01,
    PFSA_WAIT  = 5'h02,
    PFSA_READ  = 5'h04,
    PFSA_ERASE = 5'h08,
    PFSA_PROG  = 5'h10
  } pfsa_state_t;
endpackage

// ==== pkg/pfsa_regs.svh ====
// Constants for the program flash self-access block
`ifndef PFSA_REGS_SVH
`define PFSA_REGS_SVH
`define PFSA_WORD_W 14
`define PFSA_ADDR_W 15
`define PFSA_ROW_LSB 5
`define PFSA_ROW_WORDS 32
`define PFSA_LATCH_N 32
`define PFSA_LOW_MSB 7
`define PFSA_HIGH_LSB 8
`define PFSA_HIGH_W 6
`define PFSA_WRT_ALL_OFF 2'h3
`define PFSA_WRT_LOW_LIMIT 15'h0200
`define PFSA_WRT_HALF_LIMIT 15'h1000
`define PFSA_WRT_FULL_LIMIT 15'h7FFF
`define PFSA_ERASE_DATA 14'h3FFF
`endif

// ==== src/pfsa_protect.sv ====
// Write-protection address check
`timescale 1ns/10ps
`include "pfsa_regs.svh"
module pfsa_protect (
  input wire logic [1:0] write_protect_field,
  input wire logic [`PFSA_ADDR_W-1:0] addr,
  output logic blocked
);
  // Upper bound of the protected segment for each setting
  logic [`PFSA_ADDR_W-1:0] limit;
  assign limit = (write_protect_field == `PFSA_WRT_ALL_OFF) ? '0 :
                 (write_protect_field == 2'h2) ? `PFSA_WRT_LOW_LIMIT :
                 (write_protect_field == 2'h1) ? `PFSA_WRT_HALF_LIMIT :
                 `PFSA_WRT_FULL_LIMIT;
  // Lower segment protected up to limit; full setting covers all
  assign blocked = (write_protect_field == 2'h0) || (addr < limit);
endmodule

// ==== src/pfsa_top.sv ====
// Program flash self-access sequencer: reads, row erase, latch programming
// Function
// - Memory in rows of 14-bit words; row erases
// - Reject erase/write to write-protected segment
// - Data pair writes in idle load hidden 14-bit latches
// - 32-word rows and latches, aligned
// - Erased row reprogrammable wholly or partly
// - Second cycle after read strobe does array access
// - Read word appears in pair next cycle
// - Pair holds result until read or write
// - Self-read ignores code protection bit
`timescale 1ns/10ps
`include "pfsa_regs.svh"
module pfsa_top #(
  parameter int LATCH_N = `PFSA_LATCH_N,
  parameter int WORD_W = `PFSA_WORD_W
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  // Software register writes, one-cycle strobes
  input wire logic addr_low_we,
  input wire logic addr_high_we,
  input wire logic data_low_we,
  input wire logic data_high_we,
  input wire logic ctrl_we,
  input wire logic [7:0] wdata,
  input wire pfsa_pkg::pfsa_ctrl_t ctrl_wdata,
  // Configuration word fields
  input wire logic [1:0] write_protect_field,
  input wire logic code_protect_bit,
  // Array data returned for a read
  input wire logic [WORD_W-1:0] array_rdata,
  // Register views
  output logic [7:0] flash_addr_low_reg,
  output logic [7:0] flash_addr_high_reg,
  output logic [7:0] flash_data_low_reg,
  output logic [7:0] flash_data_high_reg,
  output pfsa_pkg::pfsa_ctrl_t flash_control_reg,
  output logic write_error,
  // CPU stall: instruction in this slot is dropped
  output logic cpu_ignore,
  // Array port
  output pfsa_pkg::pfsa_arr_req_t array_req,
  output logic [WORD_W-1:0] array_wdata
);
  // Register state
  logic [7:0] addr_lo_q, addr_hi_q;
  logic [WORD_W-1:0] data_q, data_d;
  pfsa_pkg::pfsa_ctrl_t ctrl_q, ctrl_d;
  pfsa_pkg::pfsa_state_t state_q, state_d;
  logic err_q, err_d, ign_q, ign_d;
  pfsa_pkg::pfsa_arr_req_t req_q, req_d;
  logic [WORD_W-1:0] wdata_q, wdata_d;
  // Hidden write latches, not addressable by software
  logic [WORD_W-1:0] latch_q [LATCH_N];
  logic [$clog2(LATCH_N)-1:0] prog_idx_q, prog_idx_d;
  logic [`PFSA_ADDR_W-1:0] full_addr, row_base;
  logic [$clog2(LATCH_N)-1:0] lat_idx;
  logic blocked, start_rd, start_wr, data_wr;

  assign full_addr = {addr_hi_q[`PFSA_ADDR_W-9:0], addr_lo_q};
  // Row base has five low bits cleared
  assign row_base = {full_addr[`PFSA_ADDR_W-1:`PFSA_ROW_LSB], {`PFSA_ROW_LSB{1'b0}}};
  // Low address bits pick the latch within the row
  assign lat_idx = full_addr[`PFSA_ROW_LSB-1:0];
  // Code protection deliberately not consulted for reads
  assign start_rd = ctrl_we && ctrl_wdata.rd && ctrl_wdata.program_memory_select
                    && !ctrl_wdata.config_space_select;
  assign start_wr = ctrl_we && ctrl_wdata.wr && !ctrl_wdata.config_space_select;
  assign data_wr = data_low_we || data_high_we;

  // Protection is checked against the full address, not only the row
  pfsa_protect u_protect (
    .write_protect_field(write_protect_field),
    .addr(full_addr),
    .blocked(blocked)
  );

  // Address registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      addr_lo_q <= 8'h00;
      addr_hi_q <= 8'h00;
    end else begin
      if (addr_low_we) addr_lo_q <= wdata;
      // Only seven address bits exist above the low byte
      if (addr_high_we) addr_hi_q <= {1'b0, wdata[6:0]};
    end
  end

  // Write latch loading from the data pair
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      for (int i = 0; i < LATCH_N; i++) latch_q[i] <= `PFSA_ERASE_DATA;
    end else if (state_q == pfsa_pkg::PFSA_IDLE && data_wr) begin
      latch_q[lat_idx] <= data_d;
    end else if (state_q == pfsa_pkg::PFSA_PROG) begin
      // Programmed latches return to erased value for the next pass;
      // the word is copied into the write data register on this same edge
      latch_q[prog_idx_q] <= `PFSA_ERASE_DATA;
    end
  end

  // Sequencer and data pair next state
  // Read: idle (strobe cycle), wait, read (stalled slot), then load.
  // Erase is a single request cycle; programming walks every latch once.
  // Control writes are only taken in idle, so one operation runs at a time.
  always_comb begin
    state_d = state_q;
    ctrl_d = ctrl_q;
    data_d = data_q;
    err_d = err_q;
    ign_d = 1'b0;
    req_d = '0;
    wdata_d = wdata_q;
    prog_idx_d = prog_idx_q;
    // Software writes to the pair overwrite the held result
    if (data_low_we) data_d[`PFSA_LOW_MSB:0] = wdata;
    if (data_high_we) data_d[WORD_W-1:`PFSA_HIGH_LSB] = wdata[`PFSA_HIGH_W-1:0];
    unique case (state_q)
      pfsa_pkg::PFSA_IDLE: begin
        if (ctrl_we) begin
          // Strobe bits stay set only for an operation that starts;
          // otherwise a refused request would leave the block looking busy
          ctrl_d = ctrl_wdata;
          ctrl_d.rd = start_rd;
          ctrl_d.wr = start_wr && !start_rd && !blocked;
        end
        if (start_rd) begin
          // Read wins over a write requested in the same control write
          state_d = pfsa_pkg::PFSA_WAIT;
        end else if (start_wr) begin
          if (blocked) begin
            // Refused: error flag only, no array activity
            err_d = 1'b1;
          end else if (ctrl_wdata.free) begin
            err_d = 1'b0;
            state_d = pfsa_pkg::PFSA_ERASE;
            req_d = '{rd: 1'b0, erase: 1'b1, prog: 1'b0, addr: row_base};
          end else begin
            err_d = 1'b0;
            state_d = pfsa_pkg::PFSA_PROG;
            prog_idx_d = '0;
          end
        end
      end
      pfsa_pkg::PFSA_WAIT: begin
        // Next cycle is the stolen slot
        state_d = pfsa_pkg::PFSA_READ;
        ign_d = 1'b1;
        req_d = '{rd: 1'b1, erase: 1'b0, prog: 1'b0, addr: full_addr};
      end
      pfsa_pkg::PFSA_READ: begin
        data_d = array_rdata;
        ctrl_d.rd = 1'b0;
        state_d = pfsa_pkg::PFSA_IDLE;
      end
      pfsa_pkg::PFSA_ERASE: begin
        ctrl_d.wr = 1'b0;
        state_d = pfsa_pkg::PFSA_IDLE;
      end
      pfsa_pkg::PFSA_PROG: begin
        // One latch per cycle into its row slot; a fresh word every cycle
        // keeps the pass at exactly one cycle per latch
        req_d = '{rd: 1'b0, erase: 1'b0, prog: 1'b1,
                  addr: row_base | {{(`PFSA_ADDR_W-$clog2(LATCH_N)){1'b0}}, prog_idx_q}};
        wdata_d = latch_q[prog_idx_q];
        if (prog_idx_q == $clog2(LATCH_N)'(LATCH_N-1)) begin
          // Last word issued; its request stands for one cycle in idle
          ctrl_d.wr = 1'b0;
          state_d = pfsa_pkg::PFSA_IDLE;
        end else begin
          prog_idx_d = prog_idx_q + 1'b1;
        end
      end
      default: state_d = pfsa_pkg::PFSA_IDLE;
    endcase
  end

  // State registers
  // Synchronous reset; every output below except the address pair comes from one of these
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q <= pfsa_pkg::PFSA_IDLE;
      ctrl_q <= '0;
      data_q <= '0;
      err_q <= 1'b0;
      ign_q <= 1'b0;
      req_q <= '0;
      wdata_q <= '0;
      prog_idx_q <= '0;
    end else begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      data_q <= data_d;
      err_q <= err_d;
      ign_q <= ign_d;
      req_q <= req_d;
      wdata_q <= wdata_d;
      prog_idx_q <= prog_idx_d;
    end
  end

  // Outputs straight from flops; high byte upper bits read zero
  assign flash_addr_low_reg = addr_lo_q;
  assign flash_addr_high_reg = addr_hi_q;
  assign flash_data_low_reg = data_q[`PFSA_LOW_MSB:0];
  assign flash_data_high_reg = {2'h0, data_q[WORD_W-1:`PFSA_HIGH_LSB]};
  assign flash_control_reg = ctrl_q;
  assign write_error = err_q;
  assign cpu_ignore = ign_q;
  assign array_req = req_q;
  assign array_wdata = wdata_q;
endmodule
